// ### design/dum_pkg.sv
// Shared constants for the dual serial modem port.
// Assumes a 100 MHz system clock and 8N1 character framing.
package dum_pkg;
    // System clock rate in Hz
    localparam int unsigned CLK_HZ       = 100_000_000;
    // Highest baud rate either port must reach, in bit/s
    localparam int unsigned MAX_BAUD     = 921_000;
    // Width of the baud divisor (clocks per bit, minus one)
    localparam int          DIV_W        = 16;
    // Smallest legal divisor, derived from the top rate (rounded down)
    localparam logic [15:0] DIV_MIN      = 16'(CLK_HZ / MAX_BAUD - 1);
    // Divisor after reset: 115200 baud at 100 MHz
    localparam logic [15:0] DIV_RESET    = 16'h0363;
    // Data bits per character
    localparam int          DATA_BITS    = 8;
    // Bit counter width
    localparam int          CNT_W        = 4;
    // Last bit index of a frame: start, 8 data, stop
    localparam logic [3:0]  LAST_BIT     = 4'h9;
    // Wiring options of the main port
    typedef enum logic [1:0] {
        DUM_WIRE8 = 2'h0,
        DUM_WIRE5 = 2'h1,
        DUM_WIRE4 = 2'h2,
        DUM_WIRE2 = 2'h3
    } dum_wiring_t;

    // Clamp a requested divisor so the rate never exceeds CLK_HZ / (DIV_MIN + 1), just above the top rate
    function automatic logic [15:0] dum_clamp_div(input logic [15:0] div);
        dum_clamp_div = (div < DIV_MIN) ? DIV_MIN : div;
    endfunction : dum_clamp_div
endpackage : dum_pkg

// ### design/dum_uart_core.sv
// One serial channel: transmit and receive engines with hardware flow.
// Assumes pins are synchronised by the caller; user side on clk.
`timescale 1ns/1ps
module dum_uart_core
(
    input  wire logic        clk,          // System clock
    input  wire logic        reset,        // Synchronous reset, high
    input  wire logic [15:0] baud_div,     // Clocks per bit minus one
    input  wire logic        flow_en,      // Hardware flow control on
    input  wire logic        host_rts,     // Host may receive (asserted)
    input  wire logic        rx_pin,       // Synchronised serial input
    output logic             tx_pin,       // Serial output, idle high
    output logic             cts_act,      // Device can accept (asserted)
    input  wire logic [7:0]  send_data,    // Byte to send to the host
    input  wire logic        send_valid,   // Send request
    output logic             send_ready,   // Send accepted this cycle
    output logic [7:0]       recv_data,    // Byte from the host
    output logic             recv_valid,   // Byte present
    input  wire logic        recv_ready,   // User takes byte
    output logic             recv_overrun  // Byte lost, sticky until reset
);
    import dum_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] div;                      // Clamped divisor
    logic [15:0] tx_tick_reg;              // Transmit bit timer
    logic [3:0]  tx_bit_reg;               // Transmit bit index
    logic        tx_busy_reg;              // Frame in progress
    logic [9:0]  tx_shift_reg;             // Frame shifter
    logic [15:0] rx_tick_reg;              // Receive bit timer
    logic [3:0]  rx_bit_reg;               // Receive bit index
    logic        rx_busy_reg;              // Receiving a frame
    logic [7:0]  rx_shift_reg;             // Receive shifter

    assign div = dum_clamp_div(baud_div);
    // Send is taken only while the host allows it, unless flow is off
    assign send_ready = !tx_busy_reg && (!flow_en || host_rts);
    // Ready to receive while no byte waits, unless flow is off
    assign cts_act = !flow_en || !recv_valid;
    assign tx_pin = tx_shift_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Transmit engine: start bit, data LSB first, stop bit
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_busy_reg  <= 1'b0;
            tx_shift_reg <= '1;
            tx_tick_reg  <= '0;
            tx_bit_reg   <= '0;
        end else if (!tx_busy_reg) begin
            if (send_valid && send_ready) begin
                tx_shift_reg <= {1'b1, send_data, 1'b0};
                tx_busy_reg  <= 1'b1;
                tx_tick_reg  <= div;
                tx_bit_reg   <= '0;
            end
        end else if (tx_tick_reg != '0) begin
            tx_tick_reg <= tx_tick_reg - 16'h0001;
        end else if (tx_bit_reg == LAST_BIT) begin
            tx_busy_reg <= 1'b0;
        end else begin
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_bit_reg   <= tx_bit_reg + 4'h1;
            tx_tick_reg  <= div;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive engine: samples mid-bit, checks the stop bit
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_busy_reg  <= 1'b0;
            rx_tick_reg  <= '0;
            rx_bit_reg   <= '0;
            rx_shift_reg <= '0;
            recv_data    <= '0;
            recv_valid   <= 1'b0;
            recv_overrun <= 1'b0;
        end else begin
            if (recv_valid && recv_ready) begin
                recv_valid <= 1'b0;
            end
            if (!rx_busy_reg) begin
                if (!rx_pin) begin
                    // Half a bit to land mid start bit
                    rx_busy_reg <= 1'b1;
                    rx_tick_reg <= {1'b0, div[15:1]};
                    rx_bit_reg  <= '0;
                end
            end else if (rx_tick_reg != '0) begin
                rx_tick_reg <= rx_tick_reg - 16'h0001;
            end else begin
                rx_tick_reg <= div;
                rx_bit_reg  <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == '0 && rx_pin) begin
                    rx_busy_reg <= 1'b0;                   // Glitch, not a start
                end else if (rx_bit_reg == LAST_BIT) begin
                    rx_busy_reg <= 1'b0;
                    if (rx_pin) begin
                        // New byte wins over a same-cycle take
                        recv_data  <= rx_shift_reg;
                        recv_valid <= 1'b1;
                        if (recv_valid && !recv_ready) begin
                            recv_overrun <= 1'b1;
                        end
                    end
                end else if (rx_bit_reg != '0) begin
                    rx_shift_reg <= {rx_pin, rx_shift_reg[7:1]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_tx_idle_high: assert property (@(posedge clk) disable iff (reset)
        !tx_busy_reg |-> tx_pin) else $error("tx line not idle high");
    a_tx_start_low: assert property (@(posedge clk) disable iff (reset)
        (send_valid && send_ready) |=> !tx_pin && tx_busy_reg)
        else $error("no start bit after send");
    // A stopped host must not see a start bit appear
    a_tx_flow_hold: assert property (@(posedge clk) disable iff (reset)
        (flow_en && !host_rts && !tx_busy_reg) |=> tx_pin)
        else $error("frame started while host stops");
    // A waiting byte keeps clear to send off until it is taken
    a_cts_full_stop: assert property (@(posedge clk) disable iff (reset)
        (flow_en && recv_valid && !recv_ready) |=> !cts_act)
        else $error("clear to send while byte waits");
    a_div_floor: assert property (@(posedge clk) disable iff (reset)
        div >= DIV_MIN) else $error("bit rate above top rate");
    c_send_frame: cover property (@(posedge clk) disable iff (reset)
        send_valid && send_ready);
    c_recv_byte: cover property (@(posedge clk) disable iff (reset)
        $rose(recv_valid));
endmodule : dum_uart_core

// ### design/dum_modem_port.sv
// Top of the dual serial modem port: main and auxiliary channels.
// Assumes pins come from another clock domain; all user ports on clk.
`timescale 1ns/1ps
module dum_modem_port
(
    input  wire logic        clk,                   // 100 MHz clock
    input  wire logic        reset,                 // Synchronous reset, high
    // Main port pins
    input  wire logic        main_tx_data_in,       // Data from host
    output logic             main_rx_data_out,      // Data to host
    input  wire logic        main_request_send_n,   // Host ready, low
    output logic             main_clear_send_n,     // Device ready, low
    output logic             main_set_ready_n,      // Device ready, low
    input  wire logic        main_terminal_ready_n, // Host present, low
    output logic             main_carrier_detect_n, // Carrier, low
    output logic             main_ring_indicate_n,  // Ring, low
    output logic             main_pins_oe,          // Main pins driven
    // Auxiliary port pins
    input  wire logic        aux_tx_data_in,        // Data from host
    output logic             aux_rx_data_out,       // Data to host
    input  wire logic        aux_request_send_n,    // Host ready, low
    output logic             aux_clear_send_n,      // Device ready, low
    // Control and status
    input  wire logic        main_enable,           // Request main service
    input  wire logic        main_gpio_busy,        // A shared GPIO in use
    output logic             main_active,           // Main service granted
    input  wire dum_pkg::dum_wiring_t main_wiring,  // Main wiring option
    input  wire logic [1:0]  main_flow_sel,         // Flow params, 0,0 = off
    input  wire logic [15:0] main_baud_div,         // Main clocks per bit - 1
    input  wire logic        aux_enable,            // Aux service on
    input  wire logic [1:0]  aux_flow_sel,          // Flow params, 0,0 = off
    input  wire logic [15:0] aux_baud_div,          // Aux clocks per bit - 1
    input  wire logic        carrier_on,            // Network carrier present
    input  wire logic        ring_on,               // Incoming call ringing
    output logic             main_terminal_ready,   // Host ready, filtered
    output logic             main_slow_idle_ok,     // Host allows slow idle
    // Main user side
    input  wire logic [7:0]  main_send_data,        // Byte to host
    input  wire logic        main_send_valid,       // Send request
    output logic             main_send_ready,       // Send taken
    output logic [7:0]       main_recv_data,        // Byte from host
    output logic             main_recv_valid,       // Byte present
    input  wire logic        main_recv_ready,       // Byte taken
    output logic             main_recv_overrun,     // Byte lost
    // Aux user side
    input  wire logic [7:0]  aux_send_data,         // Byte to host
    input  wire logic        aux_send_valid,        // Send request
    output logic             aux_send_ready,        // Send taken
    output logic [7:0]       aux_recv_data,         // Byte from host
    output logic             aux_recv_valid,        // Byte present
    input  wire logic        aux_recv_ready,        // Byte taken
    output logic             aux_recv_overrun       // Byte lost
);
    import dum_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when 2 and 3 agree
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] pin_raw;                      // Raw pin levels
    logic [NSYNC-1:0] s1_reg;                       // First stage only
    logic [NSYNC-1:0] s2_reg;                       // Second stage
    logic [NSYNC-1:0] s3_reg;                       // Third stage
    logic [NSYNC-1:0] pin_reg;                      // Accepted levels

    // Bit order: main data, terminal ready, request, aux data, aux request
    assign pin_raw = {aux_request_send_n, aux_tx_data_in,
                      main_request_send_n, main_terminal_ready_n,
                      main_tx_data_in};

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_reg  <= '1;
            s2_reg  <= '1;
            s3_reg  <= '1;
            pin_reg <= '1;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    pin_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Service grant: a busy shared GPIO keeps the port off
    always_ff @(posedge clk) begin
        if (reset) begin
            main_active <= 1'b0;
        end else begin
            main_active <= main_enable && !main_gpio_busy;
        end
    end
    assign main_pins_oe = main_active;

    ////////////////////////////////////////////////////////////////////////
    // Wiring options decide which modem lines mean anything
    logic main_flow_en;                             // Main flow active
    logic aux_flow_en;                              // Aux flow active
    logic main_full_modem;                          // DSR/DCD/RI in use
    logic main_cts_act;                             // Core says clear
    logic aux_cts_act;                              // Core says clear
    logic main_tx_raw;                              // Core serial out
    logic aux_tx_raw;                               // Core serial out

    // Two-wire, or flow parameters 0,0, turn hardware flow off
    assign main_flow_en = (main_flow_sel != 2'h0)
                          && (main_wiring != DUM_WIRE2);
    assign aux_flow_en = (aux_flow_sel != 2'h0);
    assign main_full_modem = (main_wiring == DUM_WIRE8);

    // Terminal ready follows the pin in every wiring; slow idle only in eight- and five-wire use
    always_ff @(posedge clk) begin
        if (reset) begin
            main_terminal_ready <= 1'b0;
            main_slow_idle_ok   <= 1'b0;
        end else begin
            main_terminal_ready <= !pin_reg[1] && main_active;
            // A host tied low (four/two-wire) never grants slow idle
            main_slow_idle_ok <= main_active && pin_reg[1]
                && (main_wiring == DUM_WIRE8 || main_wiring == DUM_WIRE5);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modem status outputs, registered, inactive high when unused
    always_ff @(posedge clk) begin
        if (reset) begin
            main_set_ready_n      <= 1'b1;
            main_carrier_detect_n <= 1'b1;
            main_ring_indicate_n  <= 1'b1;
            main_clear_send_n     <= 1'b1;
            main_rx_data_out      <= 1'b1;
            aux_clear_send_n      <= 1'b1;
            aux_rx_data_out       <= 1'b1;
        end else begin
            main_set_ready_n      <= !(main_active && main_full_modem);
            main_carrier_detect_n <= !(main_active && main_full_modem && carrier_on);
            main_ring_indicate_n  <= !(main_active && main_full_modem && ring_on);
            main_clear_send_n     <= !(main_active && main_cts_act);
            main_rx_data_out      <= main_active ? main_tx_raw : 1'b1;
            aux_clear_send_n      <= !(aux_enable && aux_cts_act);
            aux_rx_data_out       <= aux_enable ? aux_tx_raw : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The two channels; each core is held in reset while its service is disabled
    dum_uart_core u_main (
        .clk          (clk),
        .reset        (reset || !main_active),
        .baud_div     (main_baud_div),
        .flow_en      (main_flow_en),
        .host_rts     (!pin_reg[2]),
        .rx_pin       (pin_reg[0]),
        .tx_pin       (main_tx_raw),
        .cts_act      (main_cts_act),
        .send_data    (main_send_data),
        .send_valid   (main_send_valid),
        .send_ready   (main_send_ready),
        .recv_data    (main_recv_data),
        .recv_valid   (main_recv_valid),
        .recv_ready   (main_recv_ready),
        .recv_overrun (main_recv_overrun)
    );

    dum_uart_core u_aux (
        .clk          (clk),
        .reset        (reset || !aux_enable),
        .baud_div     (aux_baud_div),
        .flow_en      (aux_flow_en),
        .host_rts     (!pin_reg[4]),
        .rx_pin       (pin_reg[3]),
        .tx_pin       (aux_tx_raw),
        .cts_act      (aux_cts_act),
        .send_data    (aux_send_data),
        .send_valid   (aux_send_valid),
        .send_ready   (aux_send_ready),
        .recv_data    (aux_recv_data),
        .recv_valid   (aux_recv_valid),
        .recv_ready   (aux_recv_ready),
        .recv_overrun (aux_recv_overrun)
    );

    ////////////////////////////////////////////////////////////////////////
    a_grant_blocked: assert property (@(posedge clk) disable iff (reset)
        main_gpio_busy |=> !main_active) else $error("grant despite busy gpio");
    // Released pins must sit at their idle level
    a_pins_follow: assert property (@(posedge clk) disable iff (reset)
        !main_pins_oe |=> main_rx_data_out && main_set_ready_n)
        else $error("released pins not idle");
    a_status_off: assert property (@(posedge clk) disable iff (reset)
        (main_wiring != DUM_WIRE8) |=> main_set_ready_n && main_ring_indicate_n)
        else $error("modem status in reduced wiring");
    a_two_wire_flow: assert property (@(posedge clk) disable iff (reset)
        (main_wiring == DUM_WIRE2 && main_active) |=> !main_clear_send_n)
        else $error("clear to send dropped in two-wire");
    a_aux_flow_off: assert property (@(posedge clk) disable iff (reset)
        (aux_flow_sel == 2'h0 && aux_enable) |=> !aux_clear_send_n)
        else $error("aux clear to send dropped without flow");
    a_idle_dtr: assert property (@(posedge clk) disable iff (reset)
        (main_wiring == DUM_WIRE4) |=> !main_slow_idle_ok)
        else $error("slow idle in four-wire");
    a_dtr_path: assert property (@(posedge clk) disable iff (reset)
        main_active ##1 main_active |-> main_terminal_ready == !$past(pin_reg[1]))
        else $error("terminal ready not tracked");
    c_full_modem: cover property (@(posedge clk) disable iff (reset)
        main_active && !main_ring_indicate_n);
    c_two_wire: cover property (@(posedge clk) disable iff (reset)
        main_active && main_wiring == DUM_WIRE2 && main_send_valid && main_send_ready);
    c_aux_send: cover property (@(posedge clk) disable iff (reset)
        aux_send_valid && aux_send_ready);
endmodule : dum_modem_port

// ### test/dum_host_model.sv
// Host end of one serial channel: 8N1 sender and listener.
// Assumes the device line idles high and one bit lasts BIT clocks.
`timescale 1ns/1ps
module dum_host_model #(
    parameter int BIT = 108                // Clocks per bit
) (
    input  wire logic       clk,           // System clock
    input  wire logic       rx,            // Line driven by the device
    output logic            tx,            // Line towards the device
    output logic [7:0]      got,           // Last good byte heard
    output logic [7:0]      n_got          // Count of good bytes
);
    logic [7:0] sh;                        // Shift register of the listener
    initial begin
        tx = 1'b1;                         // Line idles high
        got = 8'h00;
        n_got = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////
    // Sender: start, eight data LSB first, stop; edges off the sample edge
    task automatic send_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk) tx = f[i];
            repeat (BIT - 1) @(negedge clk);
        end
    endtask : send_byte
    ////////////////////////////////////////////////////////////////////
    // Listener samples mid-bit; a low stop bit drops the byte
    always begin
        @(negedge rx);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            sh[i] = rx;
        end
        repeat (BIT) @(posedge clk);
        if (rx === 1'b1) begin
            got = sh;
            n_got = n_got + 8'h01;
        end
    end
endmodule : dum_host_model

// ### test/dum_modem_port_test.sv
// Self-checking bench for the dual serial modem port.
// Assumes host models on both channels; inputs change on falling edges.
`timescale 1ns/1ps
module dum_modem_port_test;
    import dum_pkg::*;
    localparam int BIT = 108;              // DIV_MIN + 1 clocks per bit
    logic clk, reset, main_tx_data_in, main_rx_data_out, main_request_send_n;
    logic main_clear_send_n, main_set_ready_n, main_terminal_ready_n, main_pins_oe;
    logic main_carrier_detect_n, main_ring_indicate_n, aux_tx_data_in, aux_rx_data_out;
    logic aux_request_send_n, aux_clear_send_n, main_enable, main_gpio_busy, main_active;
    logic aux_enable, carrier_on, ring_on, main_terminal_ready, main_slow_idle_ok;
    logic main_send_valid, main_send_ready, main_recv_valid, main_recv_ready;
    logic main_recv_overrun, aux_send_valid, aux_send_ready, aux_recv_valid;
    logic aux_recv_ready, aux_recv_overrun;
    dum_wiring_t main_wiring;              // Main wiring option
    logic [1:0]  main_flow_sel, aux_flow_sel;
    logic [15:0] main_baud_div, aux_baud_div;
    logic [7:0]  main_send_data, main_recv_data, aux_send_data, aux_recv_data;
    logic [7:0]  m_got, m_n, a_got, a_n;   // What the host models heard
    int          n_errors = 0;             // Mismatches
    int          num_checks = 0;           // Comparisons
    dum_modem_port u_dut (.clk, .reset, .main_tx_data_in, .main_rx_data_out,
        .main_request_send_n, .main_clear_send_n, .main_set_ready_n, .main_terminal_ready_n,
        .main_carrier_detect_n, .main_ring_indicate_n, .main_pins_oe, .aux_tx_data_in,
        .aux_rx_data_out, .aux_request_send_n, .aux_clear_send_n, .main_enable,
        .main_gpio_busy, .main_active, .main_wiring, .main_flow_sel, .main_baud_div,
        .aux_enable, .aux_flow_sel, .aux_baud_div, .carrier_on, .ring_on,
        .main_terminal_ready, .main_slow_idle_ok, .main_send_data, .main_send_valid,
        .main_send_ready, .main_recv_data, .main_recv_valid, .main_recv_ready,
        .main_recv_overrun, .aux_send_data, .aux_send_valid, .aux_send_ready,
        .aux_recv_data, .aux_recv_valid, .aux_recv_ready, .aux_recv_overrun);
    dum_host_model #(.BIT(BIT)) u_host_m (.clk(clk), .rx(main_rx_data_out),
        .tx(main_tx_data_in), .got(m_got), .n_got(m_n));
    dum_host_model #(.BIT(BIT)) u_host_a (.clk(clk), .rx(aux_rx_data_out),
        .tx(aux_tx_data_in), .got(a_got), .n_got(a_n));
    ////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;                  // 100 MHz
    // Watchdog: the tests need about 74 us, so 400 us means a hang
    initial begin
        #400_000;
        n_errors++;
        test_done();
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task test_done;
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // Hold the request until ready is seen before the taking edge
    task send(input bit aux, input logic [7:0] d);
        @(negedge clk);
        if (aux) begin
            aux_send_data = d;
            aux_send_valid = 1'b1;
        end else begin
            main_send_data = d;
            main_send_valid = 1'b1;
        end
        for (int i = 0; i < 3000 && !(aux ? aux_send_ready : main_send_ready); i++)
            @(negedge clk);
        check(aux ? aux_send_ready : main_send_ready, 8'h01);
        @(negedge clk);
        main_send_valid = 1'b0;
        aux_send_valid = 1'b0;
    endtask : send
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {main_request_send_n, main_terminal_ready_n, aux_request_send_n} = 3'b100;
        {main_enable, main_gpio_busy, aux_enable, carrier_on, ring_on} = 5'h1F;
        {main_send_valid, main_recv_ready, aux_send_valid, aux_recv_ready} = 4'h0;
        {main_send_data, aux_send_data} = 16'h0000;
        main_wiring = DUM_WIRE8;
        main_flow_sel = 2'h3;
        aux_flow_sel = 2'h0;               // Aux runs without flow
        main_baud_div = 16'h000A;          // Too fast: must be clamped
        aux_baud_div = 16'h006B;
        repeat (12) @(negedge clk);
        check({main_rx_data_out, main_clear_send_n, aux_rx_data_out}, 8'h07);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        check({main_active, main_set_ready_n}, 8'h01);
        main_gpio_busy = 1'b0;
        repeat (3) @(negedge clk);
        check({main_active, main_pins_oe, main_terminal_ready}, 8'h07);
        check({main_set_ready_n, main_carrier_detect_n, main_ring_indicate_n}, 8'h00);
        check(main_slow_idle_ok, 8'h00);
        // Host not ready: send is refused until its request line falls
        main_send_valid = 1'b1;
        repeat (20) @(negedge clk);
        check(main_send_ready, 8'h00);
        main_request_send_n = 1'b0;
        send(1'b0, 8'hA5);
        repeat (1300) @(negedge clk);
        check(m_got, 8'hA5);
        check(m_n, 8'h01);
        u_host_m.send_byte(8'h3C);
        repeat (50) @(negedge clk);
        check({main_recv_valid, main_clear_send_n}, 8'h03);
        check(main_recv_data, 8'h3C);
        main_recv_ready = 1'b1;
        @(negedge clk) main_recv_ready = 1'b0;
        repeat (3) @(negedge clk);
        check({main_recv_valid, main_clear_send_n, main_recv_overrun}, 8'h00);
        // Aux both ways, then a second byte overwrites the first while it is held
        send(1'b1, 8'h5A);
        repeat (1300) @(negedge clk);
        check(a_got, 8'h5A);
        u_host_a.send_byte(8'hC3);
        repeat (50) @(negedge clk);
        check({aux_recv_valid, aux_recv_overrun}, 8'h02);
        check(aux_recv_data, 8'hC3);
        u_host_a.send_byte(8'h81);
        repeat (50) @(negedge clk);
        check(aux_recv_data, 8'h81);
        check({aux_recv_overrun, aux_clear_send_n}, 8'h02);
        // Aux flow on: a stopped host blocks sends, a waiting byte drops clear
        aux_flow_sel = 2'h1;
        aux_request_send_n = 1'b1;
        repeat (8) @(negedge clk);
        check({aux_send_ready, aux_clear_send_n}, 8'h01);
        aux_recv_ready = 1'b1;
        @(negedge clk) aux_recv_ready = 1'b0;
        repeat (3) @(negedge clk);
        check({aux_recv_valid, aux_clear_send_n}, 8'h00);
        // Five-wire host lets terminal ready go for slow idle
        main_wiring = DUM_WIRE5;
        main_terminal_ready_n = 1'b1;
        repeat (8) @(negedge clk);
        check({main_slow_idle_ok, main_set_ready_n}, 8'h03);
        // Four-wire: host holds terminal ready low, no slow idle
        main_wiring = DUM_WIRE4;
        main_terminal_ready_n = 1'b0;
        repeat (8) @(negedge clk);
        check({main_slow_idle_ok, main_set_ready_n, main_terminal_ready}, 8'h03);
        // Two-wire: flow off, host request held low
        main_wiring = DUM_WIRE2;
        main_terminal_ready_n = 1'b0;
        main_flow_sel = 2'h0;
        repeat (4) @(negedge clk);
        check({main_slow_idle_ok, main_carrier_detect_n}, 8'h01);
        send(1'b0, 8'h0F);
        repeat (1300) @(negedge clk);
        check(m_got, 8'h0F);
        main_enable = 1'b0;
        repeat (3) @(negedge clk);
        check({main_active, main_pins_oe, main_rx_data_out, main_clear_send_n}, 8'h03);
        test_done();
    end
endmodule : dum_modem_port_test
